// ---- lpm_asserts.sv ----
`timescale 1ns/1ps
module lpm_asserts #(
  parameter NPIN = 9,
  parameter [31:0] TICK_CYCLES = 32'h1
) (
  input wire clk_sys,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  input wire tx_update,
  input wire [NPIN-1:0] tx_levels,
  input wire rx_update,
  input wire [NPIN-1:0] rx_levels,
  input wire notify_event
);
  // Ten quiet seconds plus one sample period and sync slack
  localparam int QMAX = 1100 * TICK_CYCLES + 8;
  int cyc;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      cyc <= 0;
    else if (tx_update)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_req |=> s_ans; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_tx; tx_update |=> !tx_update; endproperty
  a_tx: assert property (p_tx) else $error("tx pulse long");
  property p_notify; $rose(notify_event) |=> $fell(notify_event); endproperty
  a_notify: assert property (p_notify) else $error("notify pulse long");
  property p_mask; tx_update |-> (tx_levels & pin_oe & $past(pin_oe)) == '0; endproperty
  a_mask: assert property (p_mask) else $error("output level sent");
  property p_follow; rx_update |-> ##2 (pin_out & pin_oe) == ($past(rx_levels, 2) & pin_oe); endproperty
  a_follow: assert property (p_follow) else $error("outputs ignore remote");
  property p_oe; $changed(pin_oe) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_oe: assert property (p_oe) else $error("direction changed alone");
  property p_quiet; cyc <= QMAX; endproperty
  a_quiet: assert property (p_quiet) else $error("no quiet update");
endmodule
bind lpm_port lpm_asserts #(.NPIN(NPIN), .TICK_CYCLES(TICK_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe), .tx_update(tx_update),
  .tx_levels(tx_levels), .rx_update(rx_update), .rx_levels(rx_levels), .notify_event(notify_event)
);

// ---- lpm_defs.vh ----
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH
// Register byte addresses
`define LPM_ADDR_CTRL 8'h00
`define LPM_ADDR_DIR 8'h04
`define LPM_ADDR_FB_ON 8'h08
`define LPM_ADDR_FB_HOLD 8'h0C
`define LPM_ADDR_EMAIL 8'h10
`define LPM_ADDR_RATE 8'h14
`define LPM_ADDR_QUIET 8'h18
`define LPM_ADDR_TMO 8'h1C
`define LPM_ADDR_PINS 8'h20
`define LPM_ADDR_STATUS 8'h24
`define LPM_ADDR_MASK 8'h28
`define LPM_ADDR_TX 8'h2C
`define LPM_ADDR_RX 8'h30
// CTRL fields (write-only strobes)
`define LPM_CTRL_MASTER 0
`define LPM_CTRL_SLAVE 1
// STATUS fields
`define LPM_ST_TOGGLE 0
`define LPM_ST_TX 1
`define LPM_ST_FALLBACK 2
// Ranges and defaults
`define LPM_RATE_MIN 4'h1
`define LPM_RATE_MAX 4'hA
`define LPM_RATE_DEF 4'hA
`define LPM_QUIET_MIN 4'h1
`define LPM_QUIET_MAX 4'hA
`define LPM_QUIET_DEF 4'h2
`define LPM_TMO_MIN 5'h03
`define LPM_TMO_MAX 5'h1E
`define LPM_TMO_DEF 5'h06
// Presets
`define LPM_M_RATE 4'hA
`define LPM_M_QUIET 4'h1
`define LPM_M_TMO 5'h1E
`define LPM_M_DIR_SET 9'h00E
`define LPM_M_DIR_CLR 9'h1D0
`define LPM_M_FB_OFF 9'h00E
`define LPM_S_QUIET 4'h5
`define LPM_S_TMO 5'h06
`define LPM_S_RATE 4'hA
`define LPM_S_DIR 9'h1F0
// Timing: one second at 200 MHz
`define LPM_CLK_HZ 200000000
`define LPM_SEC_NS 1000000000
`endif

// ---- lpm_port.v ----
`timescale 1ns/1ps
`include "lpm_defs.vh"
// Functional notes
// (RL1) With notification enabled on a pin, every change of that pin raises a notification event; the code raises it for input pins only, output pins are masked.
// (RL2) With notification disabled on a pin, its changes raise no notification event.
// (RL3) An output pin with fallback on is driven on when remote updates stop.
// (RL4) An output pin with fallback off is driven off when remote updates stop; fallback only affects outputs.
// (RL5) An output pin with fallback hold keeps its present level when remote updates stop.
// (RL6) Pins are sampled 1 to 10 times per second, 10 by default.
// (RL7) A sample that differs from the previous one sends an update to the remote at once.
// (RL8) With no change for a quiet interval of 1 to 10 s, default 2 s, an update is sent anyway.
// (RL9) With no remote update for 3 to 30 s, default 6 s, each output pin takes its fallback.
// (RL10) The master preset loads 10 samples/s, 1 s quiet interval and 30 s timeout.
// (RL11) The master preset makes pins 2 to 4 outputs with fallback off and pins 5, 7, 8, 9 inputs.
// (RL12) The slave preset loads 5 s quiet, 6 s timeout, pins 1 to 4 inputs and 5 to 9 outputs with fallback off.
// (RL13) Each of the nine pins is individually input or output.
// (RL14) Each received update restarts the timeout and outputs follow received values again.
module lpm_port #(
  parameter NPIN = 9,
  parameter [31:0] TICK_CYCLES = `LPM_CLK_HZ / 100
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out,
  output reg [NPIN-1:0] pin_oe,
  output reg tx_update,
  output reg [NPIN-1:0] tx_levels,
  input wire rx_update,
  input wire [NPIN-1:0] rx_levels,
  output reg notify_event,
  output reg irq
);
  // Tick base: 100 ticks per second, so rates 1, 2, 4, 5 and 10/s divide evenly
  localparam [31:0] TICKS_PER_SEC = 32'd100;
  // Bus handshake states
  localparam [0:0] BUS_IDLE = 1'b0;
  localparam [0:0] BUS_ANSWER = 1'b1;

  reg [NPIN-1:0] dir_reg;
  reg [NPIN-1:0] fb_on_reg;
  reg [NPIN-1:0] fb_hold_reg;
  reg [NPIN-1:0] email_reg;
  reg [3:0] rate_reg;
  reg [3:0] quiet_reg;
  reg [4:0] tmo_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg [NPIN-1:0] rx_val_reg;
  reg [NPIN-1:0] prev_reg;
  reg fallback_reg;
  reg [31:0] div_reg;
  reg tick_reg;
  reg [6:0] samp_cnt_reg;
  reg [11:0] quiet_cnt_reg;
  reg [11:0] tmo_cnt_reg;
  reg bus_state_reg;
  reg bus_state_next;
  reg wait_next;

  wire [NPIN-1:0] pin_s;
  wire [6:0] samp_period;
  wire [11:0] quiet_limit;
  wire [11:0] tmo_limit;
  wire samp_now;
  wire [NPIN-1:0] diff;
  wire changed;
  wire quiet_due;
  wire tmo_due;
  wire [NPIN-1:0] toggled;
  wire ev_toggle;
  wire ev_tx;
  wire ev_fb;
  wire wr_acc;
  wire rd_acc;
  wire [NPIN-1:0] out_val;
  wire rate_ok;
  wire quiet_ok;
  wire tmo_ok;
  wire [2:0] st_clr;
  wire [2:0] st_set;

  lpm_sync3 #(
    .W(NPIN)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(pin_in),
    .q(pin_s)
  );

  function [6:0] per_div;
    input [3:0] r;
    begin
      case (r)
        4'h1: per_div = 7'd100;
        4'h2: per_div = 7'd50;
        4'h3: per_div = 7'd33;
        4'h4: per_div = 7'd25;
        4'h5: per_div = 7'd20;
        4'h6: per_div = 7'd16;
        4'h7: per_div = 7'd14;
        4'h8: per_div = 7'd12;
        4'h9: per_div = 7'd11;
        default: per_div = 7'd10;
      endcase
    end
  endfunction

  assign samp_period = per_div(rate_reg); // [RL6]
  assign quiet_limit = {8'h00, quiet_reg} * TICKS_PER_SEC[11:0];
  assign tmo_limit = {7'h00, tmo_reg} * TICKS_PER_SEC[11:0];
  assign samp_now = tick_reg && (samp_cnt_reg >= samp_period - 7'd1);
  assign diff = (pin_s ^ prev_reg) & ~dir_reg;
  assign changed = samp_now && (diff != {NPIN{1'b0}});
  assign quiet_due = tick_reg && (quiet_cnt_reg >= quiet_limit - 12'd1);
  assign tmo_due = tick_reg && !fallback_reg && (tmo_cnt_reg >= tmo_limit - 12'd1);
  assign toggled = samp_now ? (diff & email_reg) : {NPIN{1'b0}}; // [RL1] [RL2]
  assign ev_toggle = toggled != {NPIN{1'b0}};
  assign ev_tx = changed || quiet_due;
  assign ev_fb = tmo_due;
  // Write lands at the edge where the master sees waitrequest low
  assign wr_acc = avs_write && (bus_state_reg == BUS_ANSWER);
  assign rd_acc = avs_read && (bus_state_reg == BUS_IDLE);
  assign rate_ok = (avs_writedata[7:4] == 4'h0) && (avs_writedata[3:0] >= `LPM_RATE_MIN) &&
                   (avs_writedata[3:0] <= `LPM_RATE_MAX);
  assign quiet_ok = (avs_writedata[7:4] == 4'h0) && (avs_writedata[3:0] >= `LPM_QUIET_MIN) &&
                    (avs_writedata[3:0] <= `LPM_QUIET_MAX);
  assign tmo_ok = (avs_writedata[7:5] == 3'h0) && (avs_writedata[4:0] >= `LPM_TMO_MIN) &&
                  (avs_writedata[4:0] <= `LPM_TMO_MAX);
  assign st_clr = (wr_acc && avs_byteenable[0] && avs_address == `LPM_ADDR_STATUS) ? avs_writedata[2:0] : 3'h0;
  assign st_set = {ev_fb, ev_tx, ev_toggle};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_out
      // Fallback picks hold, on or off per pin; inputs are not driven
      assign out_val[g] = !fallback_reg ? rx_val_reg[g] :
                          fb_hold_reg[g] ? pin_out[g] : fb_on_reg[g]; // [RL3] [RL4] [RL5]
    end
  endgenerate

  // Tick divider
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else if (div_reg >= TICK_CYCLES - 32'd1) begin
      div_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'd1;
      tick_reg <= 1'b0;
    end
  end

  // Update pulse, sent levels and notification pulse
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_update <= 1'b0;
      tx_levels <= {NPIN{1'b0}};
      notify_event <= 1'b0;
    end else begin
      tx_update <= ev_tx; // [RL7] [RL8]
      notify_event <= ev_toggle; // [RL1]
      if (ev_tx) begin
        tx_levels <= pin_s & ~dir_reg;
      end
    end
  end

  // Sample pacing and previous sample
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      samp_cnt_reg <= 7'h00;
      prev_reg <= {NPIN{1'b0}};
    end else begin
      if (tick_reg) begin
        samp_cnt_reg <= samp_now ? 7'h00 : samp_cnt_reg + 7'd1; // [RL6]
      end
      if (samp_now) begin
        prev_reg <= pin_s;
      end
    end
  end

  // Quiet interval, restarted by every update sent
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quiet_cnt_reg <= 12'h000;
    end else if (ev_tx) begin
      quiet_cnt_reg <= 12'h000; // [RL8]
    end else if (tick_reg) begin
      quiet_cnt_reg <= quiet_cnt_reg + 12'd1;
    end
  end

  // Receive timeout; a fresh update wins over expiry
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt_reg <= 12'h000;
      fallback_reg <= 1'b0;
      rx_val_reg <= {NPIN{1'b0}};
    end else if (rx_update) begin
      tmo_cnt_reg <= 12'h000; // [RL14]
      fallback_reg <= 1'b0; // [RL14]
      rx_val_reg <= rx_levels;
    end else if (tmo_due) begin
      fallback_reg <= 1'b1; // [RL9]
    end else if (tick_reg && !fallback_reg) begin
      tmo_cnt_reg <= tmo_cnt_reg + 12'd1;
    end
  end

  // Pin drivers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe <= {NPIN{1'b0}};
    end else begin
      pin_oe <= dir_reg; // [RL13]
      pin_out <= out_val & dir_reg; // [RL4]
    end
  end

  // Avalon slave: one waitrequest cycle, then the answer for one cycle
  always @* begin
    bus_state_next = bus_state_reg;
    wait_next = 1'b1;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_next = BUS_ANSWER;
          wait_next = 1'b0;
        end
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // Avalon slave registers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_state_reg <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      avs_waitrequest <= wait_next;
      if (rd_acc) begin
        case (avs_address)
          `LPM_ADDR_DIR: avs_readdata <= {23'h000000, dir_reg};
          `LPM_ADDR_FB_ON: avs_readdata <= {23'h000000, fb_on_reg};
          `LPM_ADDR_FB_HOLD: avs_readdata <= {23'h000000, fb_hold_reg};
          `LPM_ADDR_EMAIL: avs_readdata <= {23'h000000, email_reg};
          `LPM_ADDR_RATE: avs_readdata <= {28'h0000000, rate_reg};
          `LPM_ADDR_QUIET: avs_readdata <= {28'h0000000, quiet_reg};
          `LPM_ADDR_TMO: avs_readdata <= {27'h0000000, tmo_reg};
          `LPM_ADDR_PINS: avs_readdata <= {23'h000000, pin_s};
          `LPM_ADDR_STATUS: avs_readdata <= {29'h00000000, status_reg};
          `LPM_ADDR_MASK: avs_readdata <= {29'h00000000, mask_reg};
          `LPM_ADDR_TX: avs_readdata <= {23'h000000, tx_levels};
          `LPM_ADDR_RX: avs_readdata <= {22'h000000, fallback_reg, rx_val_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration registers and presets
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dir_reg <= {NPIN{1'b0}};
      fb_on_reg <= {NPIN{1'b0}};
      fb_hold_reg <= {NPIN{1'b0}};
      email_reg <= {NPIN{1'b0}};
      rate_reg <= `LPM_RATE_DEF;
      quiet_reg <= `LPM_QUIET_DEF;
      tmo_reg <= `LPM_TMO_DEF;
      mask_reg <= 3'h0;
    end else if (wr_acc && avs_byteenable[0]) begin
      case (avs_address)
        `LPM_ADDR_CTRL: begin
          if (avs_writedata[`LPM_CTRL_MASTER]) begin
            rate_reg <= `LPM_M_RATE; // [RL10]
            quiet_reg <= `LPM_M_QUIET; // [RL10]
            tmo_reg <= `LPM_M_TMO; // [RL10]
            dir_reg <= (dir_reg | `LPM_M_DIR_SET) & ~`LPM_M_DIR_CLR; // [RL11]
            fb_on_reg <= fb_on_reg & ~`LPM_M_FB_OFF; // [RL11]
            fb_hold_reg <= fb_hold_reg & ~`LPM_M_FB_OFF; // [RL11]
          end else if (avs_writedata[`LPM_CTRL_SLAVE]) begin
            rate_reg <= `LPM_S_RATE;
            quiet_reg <= `LPM_S_QUIET; // [RL12]
            tmo_reg <= `LPM_S_TMO; // [RL12]
            dir_reg <= `LPM_S_DIR; // [RL12]
            fb_on_reg <= {NPIN{1'b0}}; // [RL12]
            fb_hold_reg <= {NPIN{1'b0}}; // [RL12]
          end
        end
        `LPM_ADDR_DIR: dir_reg <= avs_writedata[NPIN-1:0]; // [RL13]
        `LPM_ADDR_FB_ON: fb_on_reg <= avs_writedata[NPIN-1:0];
        `LPM_ADDR_FB_HOLD: fb_hold_reg <= avs_writedata[NPIN-1:0];
        `LPM_ADDR_EMAIL: email_reg <= avs_writedata[NPIN-1:0];
        `LPM_ADDR_RATE: begin
          if (rate_ok) begin
            rate_reg <= avs_writedata[3:0]; // [RL6]
          end
        end
        `LPM_ADDR_QUIET: begin
          if (quiet_ok) begin
            quiet_reg <= avs_writedata[3:0]; // [RL8]
          end
        end
        `LPM_ADDR_TMO: begin
          if (tmo_ok) begin
            tmo_reg <= avs_writedata[4:0]; // [RL9]
          end
        end
        `LPM_ADDR_MASK: mask_reg <= avs_writedata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status, write one to clear; set wins
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
      irq <= (status_reg & mask_reg) != 3'h0;
    end
  end
endmodule

// ---- lpm_remote.sv ----
`timescale 1ns/1ps
module lpm_remote (
  input wire clk_sys,
  input wire rstn,
  input wire alive,
  input wire [15:0] gap,
  input wire [8:0] levels,
  input wire tx_update,
  output logic rx_update,
  output logic [8:0] rx_levels,
  output int tx_cnt
);
  int n;
  // Update every gap+1 cycles while alive; levels churn between updates
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      n <= 0;
      rx_update <= 1'b0;
      rx_levels <= 9'h000;
      tx_cnt <= 0;
    end else begin
      tx_cnt <= tx_cnt + int'(tx_update);
      rx_update <= 1'b0;
      rx_levels <= ~rx_levels;
      n <= n + 1;
      if (alive && n >= int'(gap)) begin
        n <= 0;
        rx_update <= 1'b1;
        rx_levels <= levels;
      end
    end
  end
endmodule

// ---- lpm_sync3.v ----
`timescale 1ns/1ps
// Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
module lpm_sync3 #(
  parameter W = 9
) (
  input wire clk_sys,
  input wire rstn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "lpm_defs.vh"
module tb_top;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, tx_update, rx_update, notify_event, irq, alive;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [8:0] pin_in, pin_out, pin_oe, tx_levels, rx_levels, lv;
  logic [15:0] gap;
  int tx_cnt, error_cnt, n_checks, t0, hit;
  lpm_port #(.TICK_CYCLES(10)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .tx_update(tx_update), .tx_levels(tx_levels), .rx_update(rx_update), .rx_levels(rx_levels),
    .notify_event(notify_event), .irq(irq)
  );
  lpm_remote i_rem (
    .clk_sys(clk_sys), .rstn(rstn), .alive(alive), .gap(gap), .levels(lv), .tx_update(tx_update),
    .rx_update(rx_update), .rx_levels(rx_levels), .tx_cnt(tx_cnt)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic results;
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("answer", 1, 32'(n < 50));
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic cnt_notify;
    hit = 0;
    repeat (400) begin
      @(posedge clk_sys);
      if (notify_event === 1'b1)
        hit++;
    end
  endtask
  task automatic t_def;
    rdc(`LPM_ADDR_RATE, 32'hA);
    rdc(`LPM_ADDR_QUIET, 32'h2);
    wr(`LPM_ADDR_TMO, 32'h1F);
    rdc(`LPM_ADDR_TMO, 32'h6);
    rdc(8'h3C, 32'h0);
  endtask
  task automatic t_master;
    wr(`LPM_ADDR_DIR, 32'h1FF);
    wr(`LPM_ADDR_FB_ON, 32'h1FF);
    wr(`LPM_ADDR_FB_HOLD, 32'h1FF);
    wr(`LPM_ADDR_RATE, 32'h5);
    wr(`LPM_ADDR_CTRL, 32'h1);
    rdc(`LPM_ADDR_DIR, 32'h02F);
    rdc(`LPM_ADDR_FB_ON, 32'h1F1);
    rdc(`LPM_ADDR_FB_HOLD, 32'h1F1);
    rdc(`LPM_ADDR_RATE, 32'hA);
    rdc(`LPM_ADDR_QUIET, 32'h1);
    rdc(`LPM_ADDR_TMO, 32'h1E);
    chk("pin_oe", 32'h02F, 32'(pin_oe));
  endtask
  task automatic t_slave;
    wr(`LPM_ADDR_CTRL, 32'h2);
    rdc(`LPM_ADDR_DIR, 32'h1F0);
    rdc(`LPM_ADDR_FB_ON, 32'h000);
    rdc(`LPM_ADDR_FB_HOLD, 32'h000);
    rdc(`LPM_ADDR_QUIET, 32'h5);
    rdc(`LPM_ADDR_TMO, 32'h6);
  endtask
  task automatic t_notify;
    wr(`LPM_ADDR_EMAIL, 32'h1);
    wr(`LPM_ADDR_MASK, 32'h1);
    wr(`LPM_ADDR_STATUS, 32'h7);
    t0 = tx_cnt;
    pin_in <= 9'h001;
    cnt_notify;
    chk("notify", 1, hit);
    chk("tx", 1, 32'(tx_cnt > t0));
    rdc(`LPM_ADDR_TX, 32'h001);
    chk("irq", 1, 32'(irq));
    wr(`LPM_ADDR_STATUS, 32'h7);
    pin_in <= 9'h003;
    cnt_notify;
    chk("notify", 0, hit);
    chk("irq", 0, 32'(irq));
    rdc(`LPM_ADDR_TX, 32'h003);
    wr(`LPM_ADDR_RATE, 32'h1);
    pin_in <= 9'h002;
    cnt_notify;
    chk("slow rate", 0, hit);
    cnt_notify;
    t0 = hit;
    cnt_notify;
    chk("slow rate", 1, t0 + hit);
  endtask
  task automatic t_fall;
    wr(`LPM_ADDR_FB_ON, 32'h010);
    wr(`LPM_ADDR_FB_HOLD, 32'h020);
    wr(`LPM_ADDR_TMO, 32'h3);
    wr(`LPM_ADDR_QUIET, 32'h1);
    lv <= 9'h060;
    alive <= 1'b1;
    repeat (500) @(posedge clk_sys);
    chk("pin_out", 32'h060, 32'(pin_out & pin_oe));
    alive <= 1'b0;
    t0 = tx_cnt;
    repeat (2000) @(posedge clk_sys);
    chk("pin_out", 32'h060, 32'(pin_out & pin_oe));
    repeat (1200) @(posedge clk_sys);
    chk("pin_out", 32'h030, 32'(pin_out & pin_oe));
    chk("quiet", 1, 32'(tx_cnt - t0 >= 3 && tx_cnt - t0 <= 4));
    alive <= 1'b1;
    repeat (500) @(posedge clk_sys);
    chk("pin_out", 32'h060, 32'(pin_out & pin_oe));
  endtask
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pin_in = 9'h000;
    alive = 1'b0;
    gap = 16'hC8;
    lv = 9'h000;
    error_cnt = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_def;
    t_master;
    t_slave;
    t_notify;
    t_fall;
    results;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    results;
  end
endmodule
